/* File: ood_pkg.sv */
/*
 * Package for the off-state open-load diagnostic sequencer: register map,
 * field positions, reset values, timing counts and carrier types.
 * Assumes a single 20 MHz device clock and an AXI4-Lite register master.
 */
package ood_pkg;

   // ************************************************************
   // Geometry and timing
   // ************************************************************
   localparam int          NUM_CH            = 5;
   localparam int          CLK_HZ            = 20000000;
   localparam int          FAULT_DGL_MAX_NS  = 6000;
   // Longest time rounds down to whole cycles
   localparam int          FAULT_DGL_CYCLES  = (FAULT_DGL_MAX_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int          TEST_TIMEOUT_CYC  = 2000;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0]  ADDR_CTRL         = 8'h00;
   localparam logic [7:0]  ADDR_QUICK        = 8'h04;
   localparam logic [7:0]  ADDR_CH_BASE      = 8'h08;
   localparam logic [7:0]  ADDR_CH_LAST      = 8'h18;
   localparam logic [7:0]  ADDR_DEV          = 8'h1C;
   localparam logic [7:0]  ADDR_IO           = 8'h20;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int          CH_OLOFF_BIT      = 0;
   localparam int          CH_OLON_BIT       = 1;
   localparam int          CH_OC_LSB         = 2;
   localparam int          CH_OTW_BIT        = 5;
   localparam int          CH_OTS_BIT        = 6;
   localparam int          GL_OLF_BIT        = 8;
   localparam int          GL_OVLF_BIT       = 9;
   localparam int          GL_DSF_BIT        = 10;
   localparam int          DEV_UVF_BIT       = 1;
   localparam int          DEV_CPF_BIT       = 2;
   localparam int          DEV_OTS_BIT       = 3;
   localparam logic [4:0]  CTRL_RESET        = 5'h00;

   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   // Per-channel analogue and fault inputs
   typedef struct packed {
      logic [2:0] oc_status;
      logic       otw;
      logic       overtemp_shutdown_flag;
      logic       olon;
      logic       test_current_hit;
      logic       half_supply;
   } ood_ch_in_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_TEST  = 2'b01,
      ST_FAULT = 2'b10
   } ood_state_t;

endpackage

/* File: ood_top.sv */
/*
 * Off-state open-load diagnostic sequencer for five high-side outputs,
 * with latched open flags, quick and channel status words and a real-time
 * output level word, all reached over AXI4-Lite.
 * Assumes frame chip select and analogue comparators arrive asynchronously;
 * every such input is synchronised here before use.
 */
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps

module ood_top #(
   parameter int TIMEOUT_CYC = ood_pkg::TEST_TIMEOUT_CYC,
   parameter int DGL_CYC     = ood_pkg::FAULT_DGL_CYCLES
) (
   input  wire logic                    CLK_I,
   input  wire logic                    RST_B_I,
   input  wire logic                    CS_B_I,
   input  wire ood_pkg::ood_ch_in_t [4:0] CH_I,
   input  wire logic                    UV_I,
   input  wire logic                    CPF_I,
   input  wire logic [7:0]              AWADDR_I,
   input  wire logic                    AWVALID_I,
   output logic                         AWREADY_O,
   input  wire logic [31:0]             WDATA_I,
   input  wire logic [3:0]              WSTRB_I,
   input  wire logic                    WVALID_I,
   output logic                         WREADY_O,
   output logic [1:0]                   BRESP_O,
   output logic                         BVALID_O,
   input  wire logic                    BREADY_I,
   input  wire logic [7:0]              ARADDR_I,
   input  wire logic                    ARVALID_I,
   output logic                         ARREADY_O,
   output logic [31:0]                  RDATA_O,
   output logic [1:0]                   RRESP_O,
   output logic                         RVALID_O,
   input  wire logic                    RREADY_I,
   output logic [4:0]                   TEST_ON_O,
   output logic [4:0]                   TEST_THRESH_SEL_O
);

   localparam int N = ood_pkg::NUM_CH;

   initial begin
      if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 65535 || DGL_CYC < 1 || DGL_CYC > 255)
         $error("ood_top: timing parameter out of range");
   end

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   localparam int SW = 3 + 8 * N;
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   logic          cs_prev;

   // Two flops for every asynchronous input; stage one feeds only stage two.
   // Chip select resets to its idle high level so no false edge follows reset
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         sync1   <= {1'b1, {(SW-1){1'b0}}};
         sync2   <= {1'b1, {(SW-1){1'b0}}};
         cs_prev <= 1'b1;
      end else begin
         sync1   <= {CS_B_I, UV_I, CPF_I, CH_I};
         sync2   <= sync1;
         cs_prev <= sync2[SW-1];
      end
   end

   ood_pkg::ood_ch_in_t [4:0] ch;
   logic                      uv;
   logic                      pump_fault_flag;
   logic                      cs_rise;
   logic                      any_ots;
   logic                      fault;
   assign ch      = sync2[8*N-1:0];
   assign uv      = sync2[8*N+1];
   assign pump_fault_flag     = sync2[8*N];
   assign cs_rise = sync2[SW-1] & ~cs_prev;
   always_comb begin
      any_ots = 1'b0;
      for (int i = 0; i < N; i++) any_ots = any_ots | ch[i].overtemp_shutdown_flag;
   end
   assign fault = any_ots | uv | pump_fault_flag;

   // ************************************************************
   // Register bus
   // ************************************************************
   logic [4:0]  enable;
   logic [4:0]  next_enable;
   logic [4:0]  open_flag;
   logic [4:0]  next_open_flag;
   logic [4:0]  ch_read;
   logic        wr_go;
   logic        rd_go;
   logic        aw_ok;
   logic        ar_ok;
   logic [7:0]  aw_hold;
   logic [31:0] w_hold;
   logic [3:0]  ws_hold;
   logic        aw_have;
   logic        w_have;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   // Hold address and data separately so either may come first
   assign AWREADY_O = ~aw_have & ~BVALID_O;
   assign WREADY_O  = ~w_have & ~BVALID_O;
   assign ARREADY_O = ~RVALID_O;
   assign wr_go     = aw_have & w_have & ~BVALID_O;
   assign rd_go     = ARVALID_I & ARREADY_O;
   assign aw_ok     = (aw_hold == ood_pkg::ADDR_CTRL);
   assign ar_ok     = (ARADDR_I[1:0] == 2'h0) && (ARADDR_I <= ood_pkg::ADDR_IO);

   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         aw_have  <= 1'b0;
         w_have   <= 1'b0;
         aw_hold  <= 8'h00;
         w_hold   <= 32'h0000_0000;
         ws_hold  <= 4'h0;
         BVALID_O <= 1'b0;
         BRESP_O  <= ood_pkg::RESP_OKAY;
         RVALID_O <= 1'b0;
         RDATA_O  <= 32'h0000_0000;
         RRESP_O  <= ood_pkg::RESP_OKAY;
      end else begin
         if (AWVALID_I && AWREADY_O) begin
            aw_have <= 1'b1;
            aw_hold <= AWADDR_I;
         end
         if (WVALID_I && WREADY_O) begin
            w_have  <= 1'b1;
            w_hold  <= WDATA_I;
            ws_hold <= WSTRB_I;
         end
         if (wr_go) begin
            aw_have  <= 1'b0;
            w_have   <= 1'b0;
            BVALID_O <= 1'b1;
            BRESP_O  <= aw_ok ? ood_pkg::RESP_OKAY : ood_pkg::RESP_SLVERR;
         end else if (BREADY_I) begin
            BVALID_O <= 1'b0;
         end
         if (rd_go) begin
            RVALID_O <= 1'b1;
            RDATA_O  <= next_rdata;
            RRESP_O  <= next_rresp;
         end else if (RREADY_I) begin
            RVALID_O <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Status words
   // ************************************************************
   logic [4:0]  summary;
   logic        glb_olf;
   logic        glb_ovlf;
   logic        glb_dsf;
   logic [10:8] glb;
   logic [31:0] ch_word [N];

   // Summary and global flags are pure ORs, so they fall once reads clear sources
   always_comb begin
      glb_olf  = 1'b0;
      glb_ovlf = 1'b0;
      for (int i = 0; i < N; i++) begin
         summary[i] = (|ch[i].oc_status) | ch[i].otw | ch[i].overtemp_shutdown_flag |
                      ch[i].olon | open_flag[i];
         glb_olf  = glb_olf | ch[i].olon | open_flag[i];
         glb_ovlf = glb_ovlf | (|ch[i].oc_status) | ch[i].overtemp_shutdown_flag;
         ch_word[i] = 32'h0000_0000;
         ch_word[i][ood_pkg::CH_OLOFF_BIT] = open_flag[i];
         ch_word[i][ood_pkg::CH_OLON_BIT]  = ch[i].olon;
         ch_word[i][ood_pkg::CH_OC_LSB +: 3] = ch[i].oc_status;
         ch_word[i][ood_pkg::CH_OTW_BIT]   = ch[i].otw;
         ch_word[i][ood_pkg::CH_OTS_BIT]   = ch[i].overtemp_shutdown_flag;
      end
      glb_dsf = uv | pump_fault_flag;
      glb     = {glb_dsf, glb_ovlf, glb_olf};
   end

   // Read mux; a channel word read also marks its open flag for clearing
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp = ar_ok ? ood_pkg::RESP_OKAY : ood_pkg::RESP_SLVERR;
      ch_read    = 5'h00;
      case (ARADDR_I)
         ood_pkg::ADDR_CTRL:  next_rdata[4:0] = enable;
         ood_pkg::ADDR_QUICK: next_rdata = {21'h000000, glb, 3'h0, summary};
         ood_pkg::ADDR_DEV: begin
            next_rdata[10:8] = glb;
            next_rdata[ood_pkg::DEV_UVF_BIT] = uv;
            next_rdata[ood_pkg::DEV_CPF_BIT] = pump_fault_flag;
            next_rdata[ood_pkg::DEV_OTS_BIT] = any_ots;
         end
         ood_pkg::ADDR_IO: begin
            for (int i = 0; i < N; i++) next_rdata[i] = ch[i].half_supply;
         end
         default: begin
            for (int i = 0; i < N; i++) begin
               if (ARADDR_I == ood_pkg::ADDR_CH_BASE + 8'(4 * i)) begin
                  next_rdata = ch_word[i] | {21'h000000, glb, 8'h00};
                  ch_read[i] = rd_go;
               end
            end
         end
      endcase
   end

   // ************************************************************
   // Test sequencer
   // ************************************************************
   ood_pkg::ood_state_t state;
   ood_pkg::ood_state_t next_state;
   logic [15:0]         timer;
   logic [15:0]         next_timer;
   logic [7:0]          dgl;
   logic [7:0]          next_dgl;
   logic [4:0]          running;
   logic [4:0]          next_running;
   logic [4:0]          wr_bits;

   assign wr_bits = (wr_go && aw_ok && ws_hold[0]) ? w_hold[4:0] : enable;

   always_comb begin
      next_state     = state;
      next_timer     = timer;
      next_dgl       = dgl;
      next_running   = running;
      next_open_flag = open_flag & ~ch_read;
      // Bits of running channels are locked against writes
      next_enable    = (wr_bits & ~running) | (enable & running);
      case (state)
         ood_pkg::ST_IDLE: begin
            if (cs_rise && |enable && !fault) begin
               next_running = enable;
               next_timer   = 16'(TIMEOUT_CYC - 1);
               next_state   = ood_pkg::ST_TEST;
            end
         end
         ood_pkg::ST_TEST: begin
            for (int i = 0; i < N; i++) begin
               if (running[i] && ch[i].test_current_hit) begin
                  next_running[i] = 1'b0;
                  next_enable[i]  = 1'b0;
               end else if (running[i] && timer == 16'h0000) begin
                  next_running[i] = 1'b0;
                  next_enable[i]  = 1'b0;
                  next_open_flag[i] = 1'b1;
               end
            end
            if (timer != 16'h0000) next_timer = timer - 16'h0001;
            if (fault) begin
               next_dgl   = 8'(DGL_CYC - 1);
               next_state = ood_pkg::ST_FAULT;
            end else if (next_running == 5'h00) begin
               next_state = ood_pkg::ST_IDLE;
            end
         end
         ood_pkg::ST_FAULT: begin
            // Outputs stay on only for the deglitch, then test is abandoned
            if (dgl == 8'h00) begin
               next_enable  = enable & ~running;
               next_running = 5'h00;
               next_state   = ood_pkg::ST_IDLE;
            end else begin
               next_dgl = dgl - 8'h01;
            end
         end
         default: next_state = ood_pkg::ST_IDLE;
      endcase
      // Set above follows the read clear, so a same-cycle detection wins
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         state     <= ood_pkg::ST_IDLE;
         timer     <= 16'h0000;
         dgl       <= 8'h00;
         running   <= 5'h00;
         enable    <= ood_pkg::CTRL_RESET;
         open_flag <= 5'h00;
      end else begin
         state     <= next_state;
         timer     <= next_timer;
         dgl       <= next_dgl;
         running   <= next_running;
         enable    <= next_enable;
         open_flag <= next_open_flag;
      end
   end

   // Only the test drive; overcurrent profile logic is elsewhere and untouched
   assign TEST_ON_O         = running;
   assign TEST_THRESH_SEL_O = running;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);

   sequence s_start;
      state == ood_pkg::ST_IDLE && cs_rise && |enable && !fault;
   endsequence

   enable_reset_zero_a: assert property ($rose(RST_B_I) |-> enable == 5'h00)
      else $error("enable not cleared by reset");
   idle_no_run_a: assert property ((TEST_ON_O & ~enable) == 5'h00)
      else $error("output driven with enable cleared");
   start_latch_a: assert property (s_start |=> running == $past(enable))
      else $error("tests did not start together");
   lock_enable_a: assert property (running[0] && state == ood_pkg::ST_TEST && !fault
      && !ch[0].test_current_hit && timer != 16'h0000 |=> enable[0])
      else $error("enable changed during test");
   hit_no_flag_a: assert property (state == ood_pkg::ST_TEST && running[0]
      && ch[0].test_current_hit && !open_flag[0] |=> !open_flag[0] && !enable[0])
      else $error("hit set open flag");
   timeout_flag_a: assert property (state == ood_pkg::ST_TEST && running[2] && !fault
      && !ch[2].test_current_hit && timer == 16'h0000 |=> open_flag[2] && !running[2])
      else $error("timeout not flagged");
   read_clear_a: assert property (ch_read[2] && !running[2] |=> !open_flag[2])
      else $error("read did not clear flag");
   fault_abort_a: assert property (state == ood_pkg::ST_TEST && fault
      |-> ##[1:256] running == 5'h00)
      else $error("fault did not abort");
   summary_or_a: assert property (open_flag[2] |-> summary[2] && glb_olf)
      else $error("summary missing open");

endmodule

/* File: ood_mcu_model.sv */
/*
 * Far-side model: the microcontroller that owns the register bus and the
 * frame chip select of the off-state open-load sequencer.
 * Assumes one bus task at a time, called from the bench on the device clock.
 */
`timescale 1ns/1ps

// ************************************************************
// Master model
// ************************************************************
module ood_mcu_model (
   input  wire logic        clk_i,
   output logic             cs_b_o,
   output logic [7:0]       awaddr_o,
   output logic             awvalid_o,
   input  wire logic        awready_i,
   output logic [31:0]      wdata_o,
   output logic             wvalid_o,
   input  wire logic        wready_i,
   input  wire logic [1:0]  bresp_i,
   input  wire logic        bvalid_i,
   output logic             bready_o,
   output logic [7:0]       araddr_o,
   output logic             arvalid_o,
   input  wire logic        arready_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  rresp_i,
   input  wire logic        rvalid_i,
   output logic             rready_o
);
   // Idle bus, chip select released
   initial begin
      {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
      {araddr_o, arvalid_o, rready_o} = '0;
      cs_b_o = 1'b1;
   end

   // Handshake judged at the falling edge, acted on at the next rising one;
   // inputs only move at rising edges, so both views agree
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r,
                     output bit ok);
      bit ta, tw, tk;
      int n;
      ok = 1'b0;
      r = 2'h3;
      @(posedge clk_i);
      awaddr_o <= a;
      wdata_o <= v;
      awvalid_o <= 1'b1;
      wvalid_o <= 1'b1;
      bready_o <= 1'b1;
      for (n = 0; n < 64 && !ok; n++) begin
         @(negedge clk_i);
         ta = awvalid_o && awready_i;
         tw = wvalid_o && wready_i;
         tk = bready_o && bvalid_i;
         if (tk) r = bresp_i;
         @(posedge clk_i);
         if (ta) awvalid_o <= 1'b0;
         if (tw) wvalid_o <= 1'b0;
         if (tk) begin
            bready_o <= 1'b0;
            ok = 1'b1;
         end
      end
   endtask

   // Read: rready held from the start until the answer is seen
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                     output bit ok);
      bit ta, tk;
      int n;
      ok = 1'b0;
      d = '0;
      r = 2'h3;
      @(posedge clk_i);
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      for (n = 0; n < 64 && !ok; n++) begin
         @(negedge clk_i);
         ta = arvalid_o && arready_i;
         tk = rready_o && rvalid_i;
         if (tk) begin
            d = rdata_i;
            r = rresp_i;
         end
         @(posedge clk_i);
         if (ta) arvalid_o <= 1'b0;
         if (tk) begin
            rready_o <= 1'b0;
            ok = 1'b1;
         end
      end
   endtask

   // One frame of 400 ns; its closing rising edge launches tests
   task automatic frame();
      @(posedge clk_i);
      cs_b_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      cs_b_o <= 1'b1;
   endtask
endmodule

/* File: tb_offstate_open_load_diag.sv */
/*
 * Self-checking bench for the off-state open-load sequencer, with a small
 * integer model of enables and open flags.
 * Assumes the master model file is compiled first and shortened counts.
 */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end

module tb_offstate_open_load_diag;
   // ************************************************************
   // Signals and model state
   // ************************************************************
   localparam int TO = 20;
   localparam int DG = 10;
   logic                      clk;
   logic                      rst_b;
   logic                      cs_b, uv, pump_fault_flag, ok;
   logic [7:0]                awaddr, araddr;
   logic                      awvalid, awready, wvalid, wready, bvalid, bready;
   logic                      arvalid, arready, rvalid, rready;
   logic [31:0]               wdata, rdata, d, hs;
   logic [1:0]                bresp, rresp, resp;
   logic [4:0]                test_on, thr_sel;
   ood_pkg::ood_ch_in_t [4:0] ch;
   int                        miscompares, n_compared, seed, exp_ctrl;
   int                        exp_open [5];

   // 20 MHz device clock
   initial clk = 1'b0;
   always #25 clk = ~clk;

   ood_top #(.TIMEOUT_CYC(TO), .DGL_CYC(DG)) u_dut (
      .CLK_I(clk), .RST_B_I(rst_b), .CS_B_I(cs_b), .CH_I(ch), .UV_I(uv), .CPF_I(pump_fault_flag),
      .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
      .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
      .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
      .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
      .RREADY_I(rready), .TEST_ON_O(test_on), .TEST_THRESH_SEL_O(thr_sel));

   ood_mcu_model u_mcu (
      .clk_i(clk), .cs_b_o(cs_b), .awaddr_o(awaddr), .awvalid_o(awvalid),
      .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
      .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
      .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
      .rvalid_i(rvalid), .rready_o(rready));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // A wait that runs out ends the run at once
   task automatic lost();
      miscompares++;
      $display("[FAIL] handshake expected done seen timeout");
      close_out();
   endtask

   task automatic rd(input logic [7:0] a);
      u_mcu.rd(a, d, resp, ok);
      if (!ok) lost();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      u_mcu.wr(a, v, resp, ok);
      if (!ok) lost();
   endtask

   task automatic wait_on(input logic [4:0] m);
      for (int n = 0; n < 40 && test_on !== m; n++) @(posedge clk);
      if (test_on !== m) lost();
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      seed = 32'h33BA;
      ch = '0;
      uv = 1'b0;
      pump_fault_flag = 1'b0;
      rst_b = 1'b0;
      exp_ctrl = 0;
      exp_open = '{default: 0};
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      // Idle: no enables, a frame starts nothing
      rd(ood_pkg::ADDR_CTRL);
      `CHK("ctrl reset", exp_ctrl, d[4:0])
      u_mcu.frame();
      repeat (6) @(posedge clk);
      `CHK("idle outputs", 5'h00, test_on)
      $display("test idle done");
      // Channel 1 sees its current, channel 3 times out open
      wr(ood_pkg::ADDR_CTRL, 32'h05);
      exp_ctrl = 5;
      `CHK("write resp", ood_pkg::RESP_OKAY, resp)
      u_mcu.frame();
      wait_on(5'h05);
      `CHK("start together", 5'h05, test_on)
      `CHK("thresh sel", 5'h05, thr_sel)
      wr(ood_pkg::ADDR_CTRL, 32'h00);
      rd(ood_pkg::ADDR_CTRL);
      `CHK("ctrl locked", exp_ctrl, d[4:0])
      ch[0].test_current_hit <= 1'b1;
      repeat (5) @(posedge clk);
      exp_ctrl = 4;
      `CHK("hit off", 5'h04, test_on)
      ch[0].test_current_hit <= 1'b0;
      repeat (TO + 5) @(posedge clk);
      exp_ctrl = 0;
      exp_open[2] = 1;
      `CHK("timeout off", 5'h00, test_on)
      rd(ood_pkg::ADDR_CTRL);
      `CHK("enables cleared", exp_ctrl, d[4:0])
      rd(ood_pkg::ADDR_QUICK);
      `CHK("quick summary", 5'h04, d[4:0])
      `CHK("quick olf", 1'b1, d[ood_pkg::GL_OLF_BIT])
      rd(ood_pkg::ADDR_CH_BASE);
      `CHK("ch1 open", exp_open[0], d[0])
      `CHK("ch1 low oc", 3'h0, d[4:2])
      rd(ood_pkg::ADDR_CH_BASE + 8'h08);
      `CHK("ch3 open", exp_open[2], d[0])
      `CHK("ch3 olf", 1'b1, d[ood_pkg::GL_OLF_BIT])
      exp_open[2] = 0;
      rd(ood_pkg::ADDR_CH_BASE + 8'h08);
      `CHK("ch3 cleared", exp_open[2], d[0])
      `CHK("olf cleared", 1'b0, d[ood_pkg::GL_OLF_BIT])
      $display("test open cycle done");
      // Undervoltage in mid-test aborts well before the timeout
      wr(ood_pkg::ADDR_CTRL, 32'h02);
      u_mcu.frame();
      wait_on(5'h02);
      uv <= 1'b1;
      repeat (DG + 5) @(posedge clk);
      `CHK("abort off", 5'h00, test_on)
      rd(ood_pkg::ADDR_DEV);
      `CHK("uv reported", 1'b1, d[ood_pkg::DEV_UVF_BIT])
      rd(ood_pkg::ADDR_CH_BASE + 8'h04);
      `CHK("abort no open", exp_open[1], d[0])
      uv <= 1'b0;
      $display("test abort done");
      // Live levels, compared only while undervoltage is clear
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         hs = $random(seed);
         for (int i = 0; i < 5; i++) ch[i].half_supply <= hs[i];
         repeat (5) @(posedge clk);
         rd(ood_pkg::ADDR_IO);
         `CHK("io level", hs[4:0], d[4:0])
      end
      ch[3].otw <= 1'b1;
      repeat (5) @(posedge clk);
      rd(ood_pkg::ADDR_QUICK);
      `CHK("summary otw", 1'b1, d[3])
      ch[3].otw <= 1'b0;
      $display("test levels done");
      // Unmapped read and read-only write are refused
      rd(8'h40);
      `CHK("unmapped read", ood_pkg::RESP_SLVERR, resp)
      wr(ood_pkg::ADDR_QUICK, 32'h01);
      `CHK("readonly write", ood_pkg::RESP_SLVERR, resp)
      $display("test refusals done");
      close_out();
   end
endmodule
